//--- inc/cdcx_pkg.sv
package cdcx_pkg;
    localparam int DATA_W = 32;
    localparam int IMM_W = 16;
    localparam int REG_W = 5;
    localparam int FUNC_W = 8;
    // instruction word fields
    localparam int OP_LSB = 0;
    localparam int OP_W = 6;
    localparam int IMM_LSB = 6;
    localparam int FIELD_C_LSB = 17;
    localparam int FIELD_B_LSB = 22;
    localparam int FIELD_A_LSB = 27;
    localparam int OPX_LSB = 11;
    localparam int OPX_W = 6;
    localparam int CUST_N_LSB = 6;
    localparam int CUST_RC_BIT = 14;
    localparam int CUST_RB_BIT = 15;
    localparam int CUST_RA_BIT = 16;
    // opcodes
    localparam logic [5:0] OP_RTYPE = 6'h3A;
    localparam logic [5:0] OP_CMPLTI = 6'h10;
    localparam logic [5:0] OP_CMPLTUI = 6'h30;
    localparam logic [5:0] OP_CMPNEI = 6'h18;
    localparam logic [5:0] OP_CUSTOM = 6'h32;
    localparam logic [5:0] OPX_CMPLT = 6'h10;
    localparam logic [5:0] OPX_CMPLTU = 6'h30;
    localparam logic [5:0] OPX_CMPNE = 6'h18;
    localparam logic [5:0] OPX_DIV = 6'h25;
    // divider timing
    localparam int DIV_STEPS = 32;
    localparam logic [DATA_W-1:0] RESULT_RST = 32'h00000000;
    typedef enum logic [2:0] {
        CDCX_NONE, CDCX_LT, CDCX_LTU, CDCX_NE, CDCX_DIV, CDCX_CUST, CDCX_UNIMP
    } cdcx_op_e;
endpackage

//--- inc/cdcx_div_if.sv
`timescale 1ns/1ns
interface cdcx_div_if;
    import cdcx_pkg::*;
    logic start;
    logic [DATA_W-1:0] dividend;
    logic [DATA_W-1:0] divisor;
    logic done;
    logic [DATA_W-1:0] quotient;
    modport ctrl(output start, output dividend, output divisor,
        input done, input quotient);
    modport unit(input start, input dividend, input divisor,
        output done, output quotient);
endinterface

//--- rtl/cdcx_divider.sv
`timescale 1ns/1ns
module cdcx_divider
    import cdcx_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    cdcx_div_if.unit div
);
    logic [DATA_W-1:0] rem_ff;
    logic [DATA_W-1:0] quo_ff;
    logic [DATA_W-1:0] dsr_ff;
    logic [5:0] count_ff;
    logic negQ_ff;
    logic busy_ff;
    logic done_ff;
    logic [DATA_W:0] trial;

    function automatic logic [DATA_W-1:0] absVal(input logic [DATA_W-1:0] v);
        absVal = v[DATA_W-1] ? DATA_W'(-v) : v;
    endfunction

    assign trial = {rem_ff, quo_ff[DATA_W-1]} - {1'b0, dsr_ff};
    assign div.done = done_ff;
    assign div.quotient = negQ_ff ? DATA_W'(-quo_ff) : quo_ff;

    // restoring division on magnitudes, no trap on zero or overflow
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rem_ff <= RESULT_RST;
            quo_ff <= RESULT_RST;
            dsr_ff <= RESULT_RST;
            count_ff <= 6'h00;
            negQ_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (clkEn) begin
            done_ff <= 1'b0;
            if (div.start && !busy_ff) begin
                rem_ff <= RESULT_RST;
                quo_ff <= absVal(div.dividend); // RULE11
                dsr_ff <= absVal(div.divisor);
                negQ_ff <= div.dividend[DATA_W-1] ^ div.divisor[DATA_W-1];
                count_ff <= 6'(DIV_STEPS);
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                if (!trial[DATA_W]) begin
                    rem_ff <= trial[DATA_W-1:0];
                    quo_ff <= {quo_ff[DATA_W-2:0], 1'b1};
                end else begin
                    rem_ff <= {rem_ff[DATA_W-2:0], quo_ff[DATA_W-1]};
                    quo_ff <= {quo_ff[DATA_W-2:0], 1'b0};
                end
                count_ff <= count_ff - 6'h01;
                if (count_ff == 6'h01) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1; // RULE12 RULE13
                end
            end
        end
    end
endmodule

//--- rtl/cdcx_exec.sv
`timescale 1ns/1ns
// Contract
// RULE1 - signed register less-than writes one or zero
// RULE2 - immediate signed compare sign-extends sixteen bits
// RULE3 - unsigned register less-than writes one or zero
// RULE4 - unsigned immediate compare zero-extends sixteen bits
// RULE5 - register not-equal writes one when differing
// RULE6 - immediate not-equal sign-extends the immediate
// RULE7 - eight-bit field selects one of 256 functions
// RULE8 - at most two operands, optional one result
// RULE9 - read flags choose register value or index
// RULE10 - write flag chooses general or custom destination
// RULE11 - signed divide writes integer quotient
// RULE12 - zero divisor gives undefined value, no trap
// RULE13 - most negative by minus one, no trap
// RULE14 - divider absent raises unimplemented-instruction exception
// RULE15 - decode compare and custom opcodes
// RULE16 - compares never trap, full-word one or zero
module cdcx_exec
    import cdcx_pkg::*;
#(
    parameter bit HAS_DIV = 1'b1
)(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic issueValid,
    input wire logic [DATA_W-1:0] instrWord,
    input wire logic [DATA_W-1:0] operandA,
    input wire logic [DATA_W-1:0] operandB,
    input wire logic custDone,
    input wire logic [DATA_W-1:0] custResult,
    output logic busy_ff,
    output logic resultValid_ff,
    output logic resultWrite_ff,
    output logic [REG_W-1:0] resultReg_ff,
    output logic [DATA_W-1:0] result_ff,
    output logic unimplExc_ff,
    output logic custStart_ff,
    output logic [FUNC_W-1:0] custFunc_ff,
    output logic [DATA_W-1:0] custDataA_ff,
    output logic [DATA_W-1:0] custDataB_ff,
    output logic [REG_W-1:0] custIdxA_ff,
    output logic [REG_W-1:0] custIdxB_ff,
    output logic [REG_W-1:0] custIdxC_ff,
    output logic custReadA_ff,
    output logic custReadB_ff,
    output logic custWriteC_ff
);
    typedef enum logic [1:0] {
        CDCX_IDLE, CDCX_WAIT_DIV, CDCX_WAIT_CUST
    } cdcx_state_e;

    cdcx_state_e state_ff;
    cdcx_state_e nxt_state;
    cdcx_op_e opKind;
    cdcx_div_if divBus();
    logic divStart_ff;
    logic [DATA_W-1:0] divA_ff;
    logic [DATA_W-1:0] divB_ff;
    logic [REG_W-1:0] pendReg_ff;
    logic pendWrite_ff;
    logic [5:0] opcode;
    logic [5:0] opx;
    logic [DATA_W-1:0] immSigned;
    logic [DATA_W-1:0] immZero;
    logic [DATA_W-1:0] cmpResult;
    logic [REG_W-1:0] fieldA;
    logic [REG_W-1:0] fieldB;
    logic [REG_W-1:0] fieldC;
    logic isRType;
    logic accept;

    function automatic logic [DATA_W-1:0] toWord(input logic bitVal);
        toWord = {{(DATA_W-1){1'b0}}, bitVal}; // RULE16
    endfunction

    assign opcode = instrWord[OP_LSB +: OP_W];
    assign opx = instrWord[OPX_LSB +: OPX_W];
    assign fieldA = instrWord[FIELD_A_LSB +: REG_W];
    assign fieldB = instrWord[FIELD_B_LSB +: REG_W];
    assign fieldC = instrWord[FIELD_C_LSB +: REG_W];
    assign isRType = (opcode == OP_RTYPE);
    assign accept = issueValid && (state_ff == CDCX_IDLE);
    assign immSigned = {{(DATA_W-IMM_W){instrWord[IMM_LSB+IMM_W-1]}},
        instrWord[IMM_LSB +: IMM_W]}; // RULE2 RULE6
    assign immZero = {{(DATA_W-IMM_W){1'b0}},
        instrWord[IMM_LSB +: IMM_W]}; // RULE4

    // instruction decode
    always_comb begin
        opKind = CDCX_NONE;
        if (isRType) begin
            case (opx) // RULE15
                OPX_CMPLT: opKind = CDCX_LT;
                OPX_CMPLTU: opKind = CDCX_LTU;
                OPX_CMPNE: opKind = CDCX_NE;
                OPX_DIV: opKind = HAS_DIV ? CDCX_DIV : CDCX_UNIMP; // RULE14
                default: opKind = CDCX_NONE;
            endcase
        end else begin
            case (opcode) // RULE15
                OP_CMPLTI: opKind = CDCX_LT;
                OP_CMPLTUI: opKind = CDCX_LTU;
                OP_CMPNEI: opKind = CDCX_NE;
                OP_CUSTOM: opKind = CDCX_CUST;
                default: opKind = CDCX_NONE;
            endcase
        end
    end

    // compare datapath
    always_comb begin
        logic [DATA_W-1:0] rhs;
        rhs = operandB;
        if (!isRType) begin
            rhs = (opcode == OP_CMPLTUI) ? immZero : immSigned;
        end
        case (opKind)
            CDCX_LT: cmpResult =
                toWord($signed(operandA) < $signed(rhs)); // RULE1 RULE2
            CDCX_LTU: cmpResult = toWord(operandA < rhs); // RULE3 RULE4
            CDCX_NE: cmpResult = toWord(operandA != rhs); // RULE5 RULE6
            default: cmpResult = RESULT_RST;
        endcase
    end

    // sequencing
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CDCX_IDLE: begin
                if (accept && opKind == CDCX_DIV) begin
                    nxt_state = CDCX_WAIT_DIV;
                end else if (accept && opKind == CDCX_CUST) begin
                    nxt_state = CDCX_WAIT_CUST;
                end
            end
            CDCX_WAIT_DIV: begin
                if (divBus.done) begin
                    nxt_state = CDCX_IDLE;
                end
            end
            CDCX_WAIT_CUST: begin
                if (custDone) begin
                    nxt_state = CDCX_IDLE;
                end
            end
            default: nxt_state = CDCX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff <= CDCX_IDLE;
            busy_ff <= 1'b0;
        end else if (clkEn) begin
            state_ff <= nxt_state;
            busy_ff <= (nxt_state != CDCX_IDLE);
        end
    end

    // result write-back
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            resultValid_ff <= 1'b0;
            resultWrite_ff <= 1'b0;
            resultReg_ff <= '0;
            result_ff <= RESULT_RST;
            unimplExc_ff <= 1'b0;
            pendReg_ff <= '0;
            pendWrite_ff <= 1'b0;
        end else if (clkEn) begin
            resultValid_ff <= 1'b0;
            resultWrite_ff <= 1'b0;
            unimplExc_ff <= 1'b0;
            if (accept) begin
                case (opKind)
                    CDCX_LT, CDCX_LTU, CDCX_NE: begin
                        resultValid_ff <= 1'b1;
                        resultWrite_ff <= 1'b1;
                        resultReg_ff <= isRType ? fieldC : fieldB;
                        result_ff <= cmpResult; // RULE16
                    end
                    CDCX_DIV: begin
                        pendReg_ff <= fieldC;
                        pendWrite_ff <= 1'b1;
                    end
                    CDCX_CUST: begin
                        pendReg_ff <= fieldC;
                        pendWrite_ff <= instrWord[CUST_RC_BIT];
                    end
                    CDCX_UNIMP: begin
                        resultValid_ff <= 1'b1;
                        unimplExc_ff <= 1'b1; // RULE14
                    end
                    default: begin
                        resultValid_ff <= 1'b0;
                    end
                endcase
            end else if (state_ff == CDCX_WAIT_DIV && divBus.done) begin
                resultValid_ff <= 1'b1;
                resultWrite_ff <= pendWrite_ff;
                resultReg_ff <= pendReg_ff;
                result_ff <= divBus.quotient; // RULE11 RULE12 RULE13
            end else if (state_ff == CDCX_WAIT_CUST && custDone) begin
                resultValid_ff <= 1'b1;
                resultWrite_ff <= pendWrite_ff; // RULE10
                resultReg_ff <= pendReg_ff;
                result_ff <= custResult; // RULE8
            end
        end
    end

    // custom instruction dispatch
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            custStart_ff <= 1'b0;
            custFunc_ff <= '0;
            custDataA_ff <= RESULT_RST;
            custDataB_ff <= RESULT_RST;
            custIdxA_ff <= '0;
            custIdxB_ff <= '0;
            custIdxC_ff <= '0;
            custReadA_ff <= 1'b0;
            custReadB_ff <= 1'b0;
            custWriteC_ff <= 1'b0;
        end else if (clkEn) begin
            custStart_ff <= 1'b0;
            if (accept && opKind == CDCX_CUST) begin
                custStart_ff <= 1'b1;
                custFunc_ff <= instrWord[CUST_N_LSB +: FUNC_W]; // RULE7
                custReadA_ff <= instrWord[CUST_RA_BIT];
                custReadB_ff <= instrWord[CUST_RB_BIT];
                custWriteC_ff <= instrWord[CUST_RC_BIT]; // RULE10
                custIdxA_ff <= fieldA; // RULE9
                custIdxB_ff <= fieldB;
                custIdxC_ff <= fieldC;
                custDataA_ff <= instrWord[CUST_RA_BIT] ?
                    operandA : RESULT_RST; // RULE8 RULE9
                custDataB_ff <= instrWord[CUST_RB_BIT] ?
                    operandB : RESULT_RST; // RULE9
            end
        end
    end

    // divider launch
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            divStart_ff <= 1'b0;
            divA_ff <= RESULT_RST;
            divB_ff <= RESULT_RST;
        end else if (clkEn) begin
            divStart_ff <= accept && opKind == CDCX_DIV;
            if (accept && opKind == CDCX_DIV) begin
                divA_ff <= operandA; // RULE11
                divB_ff <= operandB;
            end
        end
    end

    assign divBus.start = divStart_ff;
    assign divBus.dividend = divA_ff;
    assign divBus.divisor = divB_ff;

    cdcx_divider u_divider (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .div(divBus.unit)
    );
endmodule

//--- sim/cdcx_exec_props.sv
`timescale 1ns/1ns
module cdcx_exec_props
    import cdcx_pkg::*;
#(
    parameter bit HAS_DIV = 1'b1
)(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic issueValid,
    input wire logic [DATA_W-1:0] instrWord,
    input wire logic [DATA_W-1:0] operandA,
    input wire logic [DATA_W-1:0] operandB,
    input wire logic custDone,
    input wire logic [DATA_W-1:0] custResult,
    input wire logic busy_ff,
    input wire logic resultValid_ff,
    input wire logic resultWrite_ff,
    input wire logic [DATA_W-1:0] result_ff,
    input wire logic unimplExc_ff,
    input wire logic custStart_ff,
    input wire logic [FUNC_W-1:0] custFunc_ff,
    input wire logic [DATA_W-1:0] custDataA_ff,
    input wire logic custReadA_ff,
    input wire logic custWriteC_ff
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic take, isR, isI, isCmp;
    logic [5:0] opc, opx;
    logic [7:0] fnum;
    logic [31:0] sx, zx;
    assign take = issueValid && clkEn && !busy_ff;
    assign opc = instrWord[5:0];
    assign opx = instrWord[16:11];
    assign fnum = instrWord[13:6];
    assign sx = {{16{instrWord[21]}}, instrWord[21:6]};
    assign zx = {16'h0000, instrWord[21:6]};
    assign isR = take && opc == OP_RTYPE;
    assign isI = take && (opc == OP_CMPLTI || opc == OP_CMPLTUI
        || opc == OP_CMPNEI);
    assign isCmp = isI || (isR && (opx == OPX_CMPLT || opx == OPX_CMPLTU
        || opx == OPX_CMPNE));
    sequence divIssue;
        isR && opx == OPX_DIV;
    endsequence
    sequence divRun;
        busy_ff[*8] ##27 (resultValid_ff && !unimplExc_ff && !busy_ff);
    endsequence
    AST_CMPLT: assert property (isR && opx == OPX_CMPLT |=>
        result_ff == 32'($signed($past(operandA)) < $signed($past(operandB))))
        else $error("signed compare wrong");
    AST_CMPLTI: assert property (take && opc == OP_CMPLTI |=>
        result_ff == 32'($signed($past(operandA)) < $signed($past(sx))))
        else $error("signed immediate compare wrong");
    AST_CMPLTU: assert property (isR && opx == OPX_CMPLTU |=>
        result_ff == 32'($past(operandA) < $past(operandB)))
        else $error("unsigned compare wrong");
    AST_CMPLTUI: assert property (take && opc == OP_CMPLTUI |=>
        result_ff == 32'($past(operandA) < $past(zx)))
        else $error("unsigned immediate compare wrong");
    AST_CMPNE: assert property (isR && opx == OPX_CMPNE |=>
        result_ff == 32'($past(operandA) != $past(operandB)))
        else $error("not-equal compare wrong");
    AST_CMPNEI: assert property (take && opc == OP_CMPNEI |=>
        result_ff == 32'($past(operandA) != $past(sx)))
        else $error("not-equal immediate wrong");
    AST_CMP_DONE: assert property (isCmp |=>
        resultValid_ff && resultWrite_ff && !unimplExc_ff && !busy_ff)
        else $error("compare not completed");
    AST_CUST_START: assert property (take && opc == OP_CUSTOM |=>
        custStart_ff && busy_ff && custFunc_ff == $past(fnum))
        else $error("custom start wrong");
    AST_CUST_OPND: assert property (custStart_ff |->
        custDataA_ff == (custReadA_ff ? $past(operandA) : 32'h00000000))
        else $error("custom operand wrong");
    AST_CUST_WB: assert property (custDone && busy_ff && !custStart_ff |=>
        resultValid_ff && resultWrite_ff == custWriteC_ff
        && result_ff == $past(custResult))
        else $error("custom writeback wrong");
    AST_DIV_START: assert property (divIssue |=>
        resultValid_ff == !HAS_DIV && unimplExc_ff == !HAS_DIV)
        else $error("divide start wrong");
    if (HAS_DIV) begin : gDiv
        AST_DIV_RUN: assert property (divIssue |=> divRun)
            else $error("divide timing wrong");
    end
endmodule

//--- sim/cdcx_cust_model.sv
`timescale 1ns/1ns
module cdcx_cust_model
    import cdcx_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic custStart_ff,
    input wire logic [FUNC_W-1:0] custFunc_ff,
    input wire logic [DATA_W-1:0] custDataA_ff,
    input wire logic [DATA_W-1:0] custDataB_ff,
    input wire logic [REG_W-1:0] custIdxA_ff,
    input wire logic [REG_W-1:0] custIdxB_ff,
    input wire logic [REG_W-1:0] custIdxC_ff,
    input wire logic custReadA_ff,
    input wire logic custReadB_ff,
    input wire logic custWriteC_ff,
    input wire logic [7:0] lat,
    output logic custDone,
    output logic [DATA_W-1:0] custResult
);
    logic [DATA_W-1:0] cReg [32];
    logic [DATA_W-1:0] res;
    int cnt;
    always @(posedge ref_clk) begin
        custDone <= 1'b0;
        custResult <= ~custResult;
        if (!rst_n) begin
            cnt = 0;
            custResult <= 32'h00000000;
            for (int i = 0; i < 32; i++) cReg[i] <= 32'(i);
        end else if (custStart_ff) begin
            cnt = lat;
            res = (custReadA_ff ? custDataA_ff : cReg[custIdxA_ff])
                + ((custReadB_ff ? custDataB_ff : cReg[custIdxB_ff])
                ^ {24'h000000, custFunc_ff});
        end else if (cnt > 0) begin
            cnt = cnt - 1;
            if (cnt == 0) begin
                custDone <= 1'b1;
                custResult <= res;
                if (!custWriteC_ff) cReg[custIdxC_ff] <= res;
            end
        end
    end
endmodule

//--- sim/test_compare_divide_custom_exec.sv
`timescale 1ns/1ns
module test_compare_divide_custom_exec;
    import cdcx_pkg::*;
    logic ref_clk, rst_n, issueValid, custDone, busy_ff, resultValid_ff;
    logic resultWrite_ff, unimplExc_ff, custStart_ff, seen;
    logic clkEn, hold, nvValid, nvExc;
    logic custReadA_ff, custReadB_ff, custWriteC_ff;
    logic [31:0] instrWord, operandA, operandB, custResult, result_ff;
    logic [31:0] custDataA_ff, custDataB_ff, a, b, vb, ins, er;
    logic [4:0] resultReg_ff, custIdxA_ff, custIdxB_ff, custIdxC_ff, dst;
    logic [7:0] custFunc_ff, lat;
    logic [31:0] cMirror [32];
    logic [31:0] corner [4] = '{32'h80000000, 32'h7FFFFFFF, 0, 32'hFFFFFFFF};
    logic [5:0] rOpx [3] = '{OPX_CMPLT, OPX_CMPLTU, OPX_CMPNE};
    logic [5:0] iOp [3] = '{OP_CMPLTI, OP_CMPLTUI, OP_CMPNEI};
    int seed = 32'h0AC8F20B;
    int failures = 0;
    int samples_checked = 0;
    int k;
    int unimplSeen = 0;
    cdcx_exec #(.HAS_DIV(1'b1)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .clkEn(clkEn), .issueValid(issueValid), .instrWord(instrWord),
        .operandA(operandA), .operandB(operandB), .custDone(custDone),
        .custResult(custResult), .busy_ff(busy_ff), .result_ff(result_ff),
        .resultValid_ff(resultValid_ff), .resultWrite_ff(resultWrite_ff),
        .resultReg_ff(resultReg_ff), .unimplExc_ff(unimplExc_ff),
        .custStart_ff(custStart_ff), .custFunc_ff(custFunc_ff),
        .custDataA_ff(custDataA_ff), .custDataB_ff(custDataB_ff),
        .custIdxA_ff(custIdxA_ff), .custIdxB_ff(custIdxB_ff),
        .custIdxC_ff(custIdxC_ff), .custReadA_ff(custReadA_ff),
        .custReadB_ff(custReadB_ff), .custWriteC_ff(custWriteC_ff));
    cdcx_cust_model i_cust (.ref_clk(ref_clk), .rst_n(rst_n),
        .custStart_ff(custStart_ff), .custFunc_ff(custFunc_ff),
        .custDataA_ff(custDataA_ff), .custDataB_ff(custDataB_ff),
        .custIdxA_ff(custIdxA_ff), .custIdxB_ff(custIdxB_ff),
        .custIdxC_ff(custIdxC_ff), .custReadA_ff(custReadA_ff),
        .custReadB_ff(custReadB_ff), .custWriteC_ff(custWriteC_ff),
        .lat(lat), .custDone(custDone), .custResult(custResult));
    // build without divider, shares all inputs
    cdcx_exec #(.HAS_DIV(1'b0)) i_nodiv (.ref_clk(ref_clk), .rst_n(rst_n),
        .clkEn(clkEn), .issueValid(issueValid), .instrWord(instrWord),
        .operandA(operandA), .operandB(operandB), .custDone(custDone),
        .custResult(custResult), .busy_ff(), .result_ff(),
        .resultValid_ff(nvValid), .resultWrite_ff(), .resultReg_ff(),
        .unimplExc_ff(nvExc), .custStart_ff(), .custFunc_ff(),
        .custDataA_ff(), .custDataB_ff(), .custIdxA_ff(), .custIdxB_ff(),
        .custIdxC_ff(), .custReadA_ff(), .custReadB_ff(),
        .custWriteC_ff());
    always @(posedge ref_clk) begin
        if (nvValid === 1'b1 && nvExc === 1'b1) unimplSeen++;
    end
    task automatic check(input string what, input logic [31:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run(input logic [31:0] i, x, y);
        int n;
        @(posedge ref_clk);
        issueValid <= 1'b1;
        clkEn <= !hold;
        instrWord <= i;
        operandA <= x;
        operandB <= y;
        @(posedge ref_clk);
        issueValid <= 1'b0;
        clkEn <= 1'b1;
        operandA <= ~x;
        operandB <= ~y;
        n = 0;
        #1;
        while (resultValid_ff !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        seen = (resultValid_ff === 1'b1);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        failures++;
        summarize();
    end
    initial begin
        rst_n = 1'b0;
        issueValid = 1'b0;
        instrWord = 0;
        operandA = 0;
        operandB = 0;
        lat = 8'h01;
        clkEn = 1'b1;
        hold = 1'b0;
        for (int i = 0; i < 32; i++) cMirror[i] = 32'(i);
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 48; i++) begin
            k = i % 6;
            a = (i < 12) ? corner[i % 4] : $random(seed);
            b = $random(seed);
            ins = $random(seed);
            if (k < 3) begin
                ins[5:0] = OP_RTYPE;
                ins[16:11] = rOpx[k];
                vb = b;
                dst = ins[21:17];
            end else begin
                ins[5:0] = iOp[k - 3];
                vb = {(k == 4) ? 16'h0000 : {16{ins[21]}}, ins[21:6]};
                dst = ins[26:22];
            end
            if (i % 12 == 7) a = vb;
            if (k < 3) b = vb;
            er = (k % 3 == 0) ? 32'($signed(a) < $signed(vb)) :
                (k % 3 == 1) ? 32'(a < vb) : 32'(a != vb);
            run(ins, a, b);
            check("cmpResult", er, result_ff);
            check("cmpDest", {dst, 1'b1},
                {resultReg_ff, resultWrite_ff});
        end
        for (int i = 0; i < 10; i++) begin
            a = (i == 1) ? 32'h80000000 : (i == 2) ? -7 : $random(seed);
            b = $random(seed) >>> (i % 24);
            b = (i == 0) ? 0 : (i == 1) ? -1 : (i == 2) ? 2 : b;
            if (i > 2 && b == 0) b = 3;
            ins = $random(seed);
            ins[5:0] = OP_RTYPE;
            ins[16:11] = OPX_DIV;
            run(ins, a, b);
            if (i > 1) check("divQuot", $signed(a) / $signed(b),
                result_ff);
            check("divExc", 2'b10, {seen, unimplExc_ff});
        end
        check("unimplCount", 32'h0000000A, unimplSeen);
        for (int i = 0; i < 16; i++) begin
            ins = $random(seed);
            ins[5:0] = OP_CUSTOM;
            ins[16:14] = 3'(i);
            if (i == 8) ins[13:6] = 8'hFF;
            if (i == 9) ins[13:6] = 8'h00;
            lat <= 8'(1 + i % 4);
            a = $random(seed);
            b = $random(seed);
            er = (ins[16] ? a : cMirror[ins[31:27]])
                + ((ins[15] ? b : cMirror[ins[26:22]]) ^ 32'(ins[13:6]));
            run(ins, a, b);
            check("custResult", er, result_ff);
            check("custFunc", 32'(ins[13:6]), 32'(custFunc_ff));
            check("custDataA", ins[16] ? a : 0, custDataA_ff);
            check("custWrite", 32'(ins[14]), 32'(resultWrite_ff));
            if (!ins[14]) cMirror[ins[21:17]] = er;
        end
        run(32'h0000003F, 1, 2);
        check("unknownOp", 0, 32'(seen));
        hold = 1'b1;
        run(32'h00000018, 1, 2);
        check("frozenIssue", 0, 32'(seen));
        hold = 1'b0;
        summarize();
    end
endmodule
bind cdcx_exec cdcx_exec_props #(.HAS_DIV(HAS_DIV)) i_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
    .issueValid(issueValid), .instrWord(instrWord), .operandA(operandA),
    .operandB(operandB), .custDone(custDone), .custResult(custResult),
    .busy_ff(busy_ff), .resultValid_ff(resultValid_ff),
    .resultWrite_ff(resultWrite_ff), .result_ff(result_ff),
    .unimplExc_ff(unimplExc_ff), .custStart_ff(custStart_ff),
    .custFunc_ff(custFunc_ff), .custDataA_ff(custDataA_ff),
    .custReadA_ff(custReadA_ff), .custWriteC_ff(custWriteC_ff));
